// ---- spicc_pkg.sv ----
// constants and types shared by the spi command and configuration block
package spicc_pkg;
   // ***********************************
   // frame layout
   // ***********************************
   localparam int FRAME_W = 16;
   localparam int ADDR_W = 5;
   localparam int CFG_W = 8;
   localparam int NUM_CFG = 3;
   localparam int ERR_BIT = 15;
   localparam int ADDR_HI = 14;
   localparam int ADDR_LO = 10;
   localparam int DATA_HI = 8;
   localparam int DATA_LO = 1;
   localparam int PAR_BIT = 0;
   localparam int STAT_BIT = 1;
   localparam int LOCK_BIT = 1;
   localparam int SWRST_BIT = 2;
   localparam int REACT_BIT = 1;
   localparam int START_BIT = 2;
   localparam int STOP_BIT = 3;

   // ***********************************
   // addresses
   // ***********************************
   localparam logic [ADDR_W-1:0] ADDR_CFG1 = 5'h01;
   localparam logic [ADDR_W-1:0] ADDR_CFG2 = 5'h02;
   localparam logic [ADDR_W-1:0] ADDR_CFG3 = 5'h03;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_FIRST = 5'h08;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_LAST = 5'h0b;
   localparam logic [ADDR_W-1:0] ADDR_LOCK_RST = 5'h0c;
   localparam logic [ADDR_W-1:0] ADDR_START = 5'h0d;

   // ***********************************
   // configuration fields and reset values
   // ***********************************
   localparam int VRS_MODE_BIT = 1;
   localparam int OT_INHIBIT_BIT = 0;
   localparam int PUMP_OFF_BIT = 1;
   localparam int IGN_LS_OFF_BIT = 0;
   localparam int FALL_FILT_BIT = 1;
   localparam int HYS_SEL_BIT = 0;
   localparam logic [NUM_CFG-1:0][CFG_W-1:0] CFG_RESET = {8'h08, 8'h08, 8'h08};
   localparam logic [1:0] IDX_CFG1 = 2'h0;
   localparam logic [1:0] IDX_CFG2 = 2'h1;
   localparam logic [1:0] IDX_CFG3 = 2'h2;

   // kinds of frame seen on the link
   typedef enum logic [2:0] {CMD_NONE, CMD_CFG, CMD_CTRL, CMD_LOCK, CMD_START} spicc_cmd_t;

   // index of a configuration register for an address
   function automatic logic [1:0] spicc_cfg_idx(input logic [ADDR_W-1:0] addr);
      logic [1:0] idx;
      idx = IDX_CFG1;
      if (addr == ADDR_CFG2) begin
         idx = IDX_CFG2;
      end else if (addr == ADDR_CFG3) begin
         idx = IDX_CFG3;
      end
      return idx;
   endfunction : spicc_cfg_idx
endpackage : spicc_pkg

// ---- spicc_cfg_if.sv ----
// write port and contents of the configuration register bank
`timescale 1ns/1ps
interface spicc_cfg_if;
   import spicc_pkg::*;
   logic wr;
   logic clr;
   logic [1:0] idx;
   logic [CFG_W-1:0] wdata;
   logic [NUM_CFG-1:0][CFG_W-1:0] cfg;
   modport ctrl (output wr, output clr, output idx, output wdata, input cfg);
   modport bank (input wr, input clr, input idx, input wdata, output cfg);
endinterface : spicc_cfg_if

// ---- spicc_parity.sv ----
// odd parity check of an incoming frame and parity of a reply
`timescale 1ns/1ps
module spicc_parity
   import spicc_pkg::*;
(
   // incoming frame
   input wire logic [FRAME_W-1:0] frame_in,
   output logic frame_ok,
   // reply body without parity
   input wire logic [FRAME_W-1:1] reply_body,
   output logic reply_par
);
   // total count of ones must be odd
   assign frame_ok = ^frame_in;
   assign reply_par = ~^reply_body;
endmodule : spicc_parity

// ---- spicc_cfg_bank.sv ----
// bank of the three configuration registers
`timescale 1ns/1ps
module spicc_cfg_bank
   import spicc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // write port
   spicc_cfg_if.bank bus
);
   // ***********************************
   // registers
   // ***********************************
   genvar g;
   generate
      for (g = 0; g < NUM_CFG; g++) begin : g_cfg
         logic [CFG_W-1:0] cfg_q;
         // device reset and soft reset both restore defaults
         always_ff @(posedge clk) begin
            if (!rst_n || bus.clr) begin
               cfg_q <= CFG_RESET[g];
            end else if (bus.wr && bus.idx == 2'(g)) begin
               cfg_q <= bus.wdata;
            end
         end
         assign bus.cfg[g] = cfg_q;
      end
   endgenerate
endmodule : spicc_cfg_bank

// ---- spicc_cmd_regs.sv ----
// spi command decoder with lock, soft reset, output disable and configuration
`timescale 1ns/1ps

// Functional notes
// - bit 0 is odd parity in both directions; device checks and generates it.
// - lock command blocks configuration writes; reply shows lock in bit 1.
// - after any reset configuration is unlocked.
// - locked bits keep acting; writes accepted only while unlocked.
// - a written configuration value acts at the end of its own frame.
// - soft reset bit clears configuration and diagnostics, switches drivers off.
// - undefined input bits of both commands are ignored.
// - start bit clears output disable; reply bit 1 shows it; stop in bit 3.
// - with outputs enabled control register writes reach the power stages.
// - output disable set after reset; control writes dropped while set.
// - while outputs disabled all power stages are held off.
// - reactivate bit turns the main relay driver back on after overcurrent.
// - config 1 bit 1 selects sensor mode, 0 limited, 1 full adaptive.
// - config 1 bit 0 set keeps relay on at overtemperature.
// - config 2 bit 0 set forces ignition low side off.
// - config 3 bit 0 selects hysteresis feedback after the adaptive filter.
// - lock/reset command at 0x0c, start/reactivate at 0x0d, write only.
module spicc_cmd_regs
   import spicc_pkg::*;
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // received frame
   input wire logic FRAME_VALID,
   input wire logic [FRAME_W-1:0] FRAME_IN,
   // reply frame
   output logic REPLY_VALID,
   output logic [FRAME_W-1:0] REPLY_OUT,
   // control register write towards the power stages
   output logic CTRL_WRITE,
   output logic [ADDR_W-1:0] CTRL_ADDR,
   output logic [CFG_W-1:0] CTRL_DATA,
   // status and events
   output logic CONFIG_LOCKED,
   output logic OUTPUTS_DISABLED_FLAG,
   output logic POWER_STAGES_ENABLE,
   output logic SOFT_RESET_REQUEST,
   output logic RELAY_REACTIVATE_REQUEST,
   // configuration bits
   output logic RELUCTANCE_SENSOR_FULL_ADAPTIVE,
   output logic RELAY_OVERTEMP_OFF_INHIBIT,
   output logic CHARGE_PUMP_OFF,
   output logic IGNITION_LOWSIDE_FORCE_OFF,
   output logic FALLING_EDGE_FILTER_ENABLE,
   output logic HYSTERESIS_FEEDBACK_SELECT
);
   // ***********************************
   // frame fields
   // ***********************************
   logic frame_ok;
   logic take;
   logic [ADDR_W-1:0] addr;
   logic [CFG_W-1:0] data;
   spicc_cmd_t cmd;

   // fields of the incoming frame; bit 15 of the input only counts towards parity
   assign addr = FRAME_IN[ADDR_HI:ADDR_LO];
   assign data = FRAME_IN[DATA_HI:DATA_LO];

   // parity check of input and generation for the reply
   logic [FRAME_W-1:1] reply_body;
   logic reply_par;
   spicc_parity u_parity (
      .frame_in(FRAME_IN),
      .frame_ok(frame_ok),
      .reply_body(reply_body),
      .reply_par(reply_par)
   );

   // only frames with good odd parity have any effect beyond the reply and error flag
   assign take = FRAME_VALID && frame_ok;

   // ***********************************
   // address decoding
   // ***********************************
   // addresses outside this block decode to no command
   always_comb begin
      if (addr == ADDR_CFG1 || addr == ADDR_CFG2 || addr == ADDR_CFG3) begin
         cmd = CMD_CFG;
      end else if (addr >= ADDR_CTRL_FIRST && addr <= ADDR_CTRL_LAST) begin
         cmd = CMD_CTRL;
      end else if (addr == ADDR_LOCK_RST) begin
         cmd = CMD_LOCK;
      end else if (addr == ADDR_START) begin
         cmd = CMD_START;
      end else begin
         cmd = CMD_NONE;
      end
   end

   // ***********************************
   // command strobes
   // ***********************************
   logic is_lock;
   logic is_start;
   logic soft_rst;
   logic start_req;
   logic stop_req;
   logic react_req;
   logic is_cfg;

   // only the defined bits of each command are looked at
   assign is_lock = take && cmd == CMD_LOCK;
   assign is_start = take && cmd == CMD_START;
   assign soft_rst = is_lock && FRAME_IN[SWRST_BIT];
   assign start_req = is_start && FRAME_IN[START_BIT];
   assign stop_req = is_start && FRAME_IN[STOP_BIT];
   assign react_req = is_start && FRAME_IN[REACT_BIT];

   // a good frame addressed to a configuration register
   assign is_cfg = take && cmd == CMD_CFG;

   // ***********************************
   // lock state
   // ***********************************
   logic lock_q;
   logic lock_d;

   logic lock_req;

   // bit 1 of the lock frame writes the lock state directly
   assign lock_req = FRAME_IN[LOCK_BIT];

   // soft reset leaves the bank unlocked and wins over the lock bit
   assign lock_d = soft_rst ? 1'b0 : (is_lock ? lock_req : lock_q);

   // unlocked from any reset
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         lock_q <= 1'b0;
      end else begin
         lock_q <= lock_d;
      end
   end

   // ***********************************
   // output disable state
   // ***********************************
   logic outputs_disabled_flag_q;
   logic outputs_disabled_flag_d;

   logic dis_set;
   logic dis_clr;

   // soft reset and stop disable, start enables
   assign dis_set = soft_rst || stop_req;
   assign dis_clr = start_req;

   // stop wins over start when both bits are set
   assign outputs_disabled_flag_d = dis_set ? 1'b1 : (dis_clr ? 1'b0 : outputs_disabled_flag_q);

   // disabled after device reset
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         outputs_disabled_flag_q <= 1'b1;
      end else begin
         outputs_disabled_flag_q <= outputs_disabled_flag_d;
      end
   end

   // ***********************************
   // configuration bank
   // ***********************************
   spicc_cfg_if cfg_bus ();

   // writes go in only while unlocked and act from the frame's own edge
   assign cfg_bus.wr = is_cfg && !lock_q;
   assign cfg_bus.clr = soft_rst;
   assign cfg_bus.idx = spicc_cfg_idx(addr);
   assign cfg_bus.wdata = data;

   spicc_cfg_bank u_bank (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .bus(cfg_bus)
   );

   // configuration bits drive their functions whether locked or not
   assign RELUCTANCE_SENSOR_FULL_ADAPTIVE = cfg_bus.cfg[IDX_CFG1][VRS_MODE_BIT];
   assign RELAY_OVERTEMP_OFF_INHIBIT = cfg_bus.cfg[IDX_CFG1][OT_INHIBIT_BIT];
   assign CHARGE_PUMP_OFF = cfg_bus.cfg[IDX_CFG2][PUMP_OFF_BIT];
   assign IGNITION_LOWSIDE_FORCE_OFF = cfg_bus.cfg[IDX_CFG2][IGN_LS_OFF_BIT];
   assign FALLING_EDGE_FILTER_ENABLE = cfg_bus.cfg[IDX_CFG3][FALL_FILT_BIT];
   assign HYSTERESIS_FEEDBACK_SELECT = cfg_bus.cfg[IDX_CFG3][HYS_SEL_BIT];

   // ***********************************
   // control register path
   // ***********************************
   logic is_ctrl;
   logic ctrl_wr_d;
   logic ctrl_wr_q;
   logic [ADDR_W-1:0] ctrl_addr_q;
   logic [CFG_W-1:0] ctrl_data_q;

   // a good frame addressed to one of the control registers
   assign is_ctrl = take && cmd == CMD_CTRL;

   // control writes are dropped while outputs are disabled
   assign ctrl_wr_d = is_ctrl && !outputs_disabled_flag_q;

   // one-cycle write strobe towards the power stages
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         ctrl_wr_q <= 1'b0;
      end else begin
         ctrl_wr_q <= ctrl_wr_d;
      end
   end

   // address of the last accepted control write
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         ctrl_addr_q <= '0;
      end else if (ctrl_wr_d) begin
         ctrl_addr_q <= addr;
      end
   end

   // data of the last accepted control write
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         ctrl_data_q <= '0;
      end else if (ctrl_wr_d) begin
         ctrl_data_q <= data;
      end
   end

   // ***********************************
   // event pulses and stage enable
   // ***********************************
   logic soft_rst_q;
   logic react_q;
   logic stages_en_q;

   // soft reset pulse for the rest of the device
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= soft_rst;
      end
   end

   // relay reactivate pulse; the relay driver decides whether it was tripped
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         react_q <= 1'b0;
      end else begin
         react_q <= react_req;
      end
   end

   // stage gate follows the next disable state so that it never lags the flag
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         stages_en_q <= 1'b0;
      end else begin
         stages_en_q <= !outputs_disabled_flag_d;
      end
   end

   // ***********************************
   // frame error flag
   // ***********************************
   logic err_q;
   logic err_d;

   // each frame reports the previous one, then records its own parity
   assign err_d = FRAME_VALID ? !frame_ok : err_q;

   // cleared by device reset only
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         err_q <= 1'b0;
      end else begin
         err_q <= err_d;
      end
   end

   // ***********************************
   // reply frame
   // ***********************************
   logic lock_stat;
   logic start_stat;
   logic stat_bit;
   logic reply_valid_q;
   logic [FRAME_W-1:0] reply_q;

   // status of each command after its own frame has acted
   assign lock_stat = is_lock ? lock_d : 1'b0;
   assign start_stat = is_start ? outputs_disabled_flag_d : 1'b0;

   // bit 1 shows lock or output disable, zero for every other frame
   assign stat_bit = lock_stat || start_stat;

   // error, echoed address, zero data field and status bit
   always_comb begin
      reply_body = '0;
      reply_body[ERR_BIT] = err_q;
      reply_body[ADDR_HI:ADDR_LO] = addr;
      reply_body[STAT_BIT] = stat_bit;
   end

   // one reply pulse for every frame, good or bad
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         reply_valid_q <= 1'b0;
      end else begin
         reply_valid_q <= FRAME_VALID;
      end
   end

   // reply word with odd parity, held until the next frame
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         reply_q <= '0;
      end else if (FRAME_VALID) begin
         reply_q <= {reply_body, reply_par};
      end
   end

   // ***********************************
   // outputs
   // ***********************************
   // reply and accepted control write
   assign REPLY_VALID = reply_valid_q;
   assign REPLY_OUT = reply_q;
   assign CTRL_WRITE = ctrl_wr_q;
   assign CTRL_ADDR = ctrl_addr_q;
   assign CTRL_DATA = ctrl_data_q;

   // status levels and event pulses
   assign CONFIG_LOCKED = lock_q;
   assign OUTPUTS_DISABLED_FLAG = outputs_disabled_flag_q;
   assign POWER_STAGES_ENABLE = stages_en_q;
   assign SOFT_RESET_REQUEST = soft_rst_q;
   assign RELAY_REACTIVATE_REQUEST = react_q;
endmodule : spicc_cmd_regs

// ---- spicc_cmd_regs_monitor.sv ----
// assertion checker for the spi command and configuration block
`timescale 1ns/1ps
module spicc_cmd_regs_monitor
   import spicc_pkg::*;
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // frames
   input wire logic FRAME_VALID,
   input wire logic [FRAME_W-1:0] FRAME_IN,
   input wire logic REPLY_VALID,
   input wire logic [FRAME_W-1:0] REPLY_OUT,
   // status and events
   input wire logic CTRL_WRITE,
   input wire logic CONFIG_LOCKED,
   input wire logic OUTPUTS_DISABLED_FLAG,
   input wire logic POWER_STAGES_ENABLE,
   input wire logic SOFT_RESET_REQUEST,
   input wire logic RELAY_REACTIVATE_REQUEST
);
   // decode of the frame being taken
   wire logic good = FRAME_VALID & (^FRAME_IN);
   wire logic bad = FRAME_VALID & ~(^FRAME_IN);
   wire logic [ADDR_W-1:0] adr = FRAME_IN[ADDR_HI:ADDR_LO];
   wire logic to_lock = good & (adr == ADDR_LOCK_RST);
   wire logic to_start = good & (adr == ADDR_START);
   wire logic lock_val = FRAME_IN[LOCK_BIT];

   // parity result of the last frame, reported in the following reply
   logic last_bad_q;
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         last_bad_q <= 1'b0;
      end else if (FRAME_VALID) begin
         last_bad_q <= bad;
      end
   end

   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);

   AST_REPLY_PULSE: assert property (REPLY_VALID == $past(FRAME_VALID)) else $error("reply pulse");
   AST_REPLY_PARITY: assert property (REPLY_VALID |-> ^REPLY_OUT) else $error("reply parity");
   AST_REPLY_ADDR: assert property (FRAME_VALID |=> REPLY_OUT[ADDR_HI:ADDR_LO] == $past(adr))
      else $error("reply address");
   AST_LOCK_CMD: assert property (to_lock && !FRAME_IN[SWRST_BIT] |=>
      CONFIG_LOCKED == $past(lock_val) && REPLY_OUT[STAT_BIT] == CONFIG_LOCKED) else $error("lock state");
   AST_LOCK_ZEROS: assert property (to_lock |=> REPLY_OUT[9:2] == 8'h00) else $error("lock reply");
   AST_SOFT_RESET: assert property (to_lock && FRAME_IN[SWRST_BIT] |=>
      SOFT_RESET_REQUEST && !CONFIG_LOCKED && OUTPUTS_DISABLED_FLAG) else $error("soft reset");
   AST_START: assert property (to_start && FRAME_IN[START_BIT] && !FRAME_IN[STOP_BIT] |=>
      !OUTPUTS_DISABLED_FLAG && !REPLY_OUT[STAT_BIT]) else $error("start");
   AST_CTRL_GATE: assert property (CTRL_WRITE |-> !$past(OUTPUTS_DISABLED_FLAG)) else $error("ctrl gate");
   AST_STAGES_OFF: assert property (POWER_STAGES_ENABLE == !OUTPUTS_DISABLED_FLAG) else $error("stages");
   AST_BAD_PARITY: assert property (bad |=> $stable(CONFIG_LOCKED) && !CTRL_WRITE &&
      !SOFT_RESET_REQUEST && $stable(OUTPUTS_DISABLED_FLAG)) else $error("bad parity");
   AST_ERR_FLAG: assert property (FRAME_VALID |=> REPLY_OUT[ERR_BIT] == $past(last_bad_q))
      else $error("error flag");
   AST_REACT: assert property (to_start && FRAME_IN[REACT_BIT] |=> RELAY_REACTIVATE_REQUEST)
      else $error("reactivate");
endmodule : spicc_cmd_regs_monitor

bind spicc_cmd_regs spicc_cmd_regs_monitor mon (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
   .FRAME_VALID(FRAME_VALID), .FRAME_IN(FRAME_IN), .REPLY_VALID(REPLY_VALID), .REPLY_OUT(REPLY_OUT),
   .CTRL_WRITE(CTRL_WRITE), .CONFIG_LOCKED(CONFIG_LOCKED), .OUTPUTS_DISABLED_FLAG(OUTPUTS_DISABLED_FLAG),
   .POWER_STAGES_ENABLE(POWER_STAGES_ENABLE), .SOFT_RESET_REQUEST(SOFT_RESET_REQUEST),
   .RELAY_REACTIVATE_REQUEST(RELAY_REACTIVATE_REQUEST));

// ---- spicc_host_model.sv ----
// host microcontroller model that sends command frames
`timescale 1ns/1ps
module spicc_host_model
   import spicc_pkg::*;
(
   // clock
   input wire logic clk,
   // frame towards the device
   output logic frame_valid,
   output logic [FRAME_W-1:0] frame
);
   initial begin
      frame_valid = 1'b0;
      frame = 16'h5a5a;
   end

   // one frame per call; bad flips the parity on purpose
   task automatic send(input logic [ADDR_W-1:0] a, input logic [CFG_W-1:0] d, input logic bad,
      input logic [1:0] dc);
      logic [FRAME_W-1:1] body;
      body = {dc[1], a, dc[0], d};
      @(posedge clk);
      #1;
      frame_valid = 1'b1;
      frame = {body, ~(^body) ^ bad};
      @(posedge clk);
      #1;
      frame_valid = 1'b0;
      frame = ~frame; // no stale frame left on the lines
   endtask : send
endmodule : spicc_host_model

// ---- tb_spicc_cmd_regs.sv ----
// self-checking testbench of the spi command and configuration block
`timescale 1ns/1ps
module tb_spicc_cmd_regs
   import spicc_pkg::*;
;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   wire logic frame_valid;
   wire logic [15:0] frame_in;
   logic reply_valid, ctrl_write, locked, dis, pwr, swrst, react;
   logic [15:0] reply;
   logic [4:0] ctrl_addr;
   logic [7:0] ctrl_data;
   logic [5:0] bits;
   logic [2:0][7:0] cfg;
   logic [31:0] rng = 32'h73137385;
   logic prev_bad = 1'b0;
   int fail_count = 0;
   int num_checks = 0;

   always #5 sys_clk = ~sys_clk;

   spicc_host_model hst (.clk(sys_clk), .frame_valid(frame_valid), .frame(frame_in));

   spicc_cmd_regs dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .FRAME_VALID(frame_valid), .FRAME_IN(frame_in),
      .REPLY_VALID(reply_valid), .REPLY_OUT(reply), .CTRL_WRITE(ctrl_write), .CTRL_ADDR(ctrl_addr),
      .CTRL_DATA(ctrl_data), .CONFIG_LOCKED(locked), .OUTPUTS_DISABLED_FLAG(dis), .POWER_STAGES_ENABLE(pwr),
      .SOFT_RESET_REQUEST(swrst), .RELAY_REACTIVATE_REQUEST(react),
      .RELUCTANCE_SENSOR_FULL_ADAPTIVE(bits[5]), .RELAY_OVERTEMP_OFF_INHIBIT(bits[4]),
      .CHARGE_PUMP_OFF(bits[3]), .IGNITION_LOWSIDE_FORCE_OFF(bits[2]),
      .FALLING_EDGE_FILTER_ENABLE(bits[1]), .HYSTERESIS_FEEDBACK_SELECT(bits[0]));

   // xorshift source of stimulus
   function automatic logic [7:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[7:0];
   endfunction : rnd

   // expected function bits from the expected register contents
   function automatic logic [15:0] exp_bits(input logic [2:0][7:0] c);
      return {10'h000, c[0][1:0], c[1][1:0], c[2][1:0]};
   endfunction : exp_bits

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // send a frame and check the common reply fields
   task automatic tx(input logic [4:0] a, input logic [7:0] d, input logic bad);
      logic [7:0] dc;
      dc = rnd();
      hst.send(a, d, bad, dc[1:0]);
      chk(16'(reply_valid), 16'h0001);
      chk(16'(^reply), 16'h0001);
      chk(16'(reply[15]), 16'(prev_bad));
      prev_bad = bad;
   endtask : tx

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   // hang guard
   initial begin
      repeat (5000) @(posedge sys_clk);
      fail_count++;
      print_verdict();
   end

   // main sequence
   initial begin
      logic [7:0] d;
      logic [4:0] a;
      cfg = 24'h080808;
      repeat (2) @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      chk(16'({locked, dis, pwr}), 16'h0002);
      chk(16'(bits), exp_bits(cfg));
      tx(5'h08, rnd(), 1'b0);
      chk(16'(ctrl_write), 16'h0000);
      $display("reset and disabled gate done");
      tx(5'h0d, (rnd() & 8'hf8) | 8'h02, 1'b0);
      chk(16'({dis, pwr, reply[1]}), 16'h0002);
      for (int i = 0; i < 4; i++) begin
         d = rnd();
         tx(5'h08 + 5'(i), d, 1'b0);
         chk(16'({ctrl_write, ctrl_addr, ctrl_data}), {2'b00, 1'b1, 5'h08 + 5'(i), d});
      end
      $display("start and control done");
      for (int i = 0; i < 16; i++) begin
         d = rnd();
         a = 5'd1 + 5'(d % 3);
         tx(a, d, i == 5 || i == 6);
         if (i != 5 && i != 6) begin
            cfg[a - 5'd1] = d;
         end
         chk(16'(bits), exp_bits(cfg));
      end
      $display("configuration done");
      tx(5'h0d, (rnd() & 8'hf8) | 8'h01, 1'b0);
      chk(16'({react, dis}), 16'h0002);
      tx(5'h0d, (rnd() & 8'hf8) | 8'h06, 1'b0);
      chk(16'({dis, pwr, reply[1]}), 16'h0005);
      tx(5'h09, rnd(), 1'b0);
      chk(16'(ctrl_write), 16'h0000);
      tx(5'h1f, rnd(), 1'b0);
      chk(16'({ctrl_write, reply[1]}), 16'h0000);
      $display("reactivate and stop done");
      tx(5'h0c, (rnd() & 8'hfc) | 8'h01, 1'b0);
      chk(16'({locked, reply[9:1]}), 16'h0201);
      tx(5'h02, ~cfg[1], 1'b0);
      chk(16'(bits), exp_bits(cfg));
      reset_n = 1'b0;
      @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      prev_bad = 1'b0;
      cfg = 24'h080808;
      chk(16'({locked, dis}), 16'h0001);
      chk(16'(bits), exp_bits(cfg));
      d = rnd() | 8'h03;
      tx(5'h03, d, 1'b0);
      cfg[2] = d;
      chk(16'(bits), exp_bits(cfg));
      $display("lock and reset done");
      tx(5'h0d, (rnd() & 8'hf8) | 8'h02, 1'b0);
      chk(16'(dis), 16'h0000);
      tx(5'h0c, (rnd() & 8'hfc) | 8'h03, 1'b0);
      cfg = 24'h080808;
      chk(16'({swrst, locked, dis}), 16'h0005);
      chk(16'(bits), exp_bits(cfg));
      $display("soft reset done");
      print_verdict();
   end
endmodule : tb_spicc_cmd_regs
